// ### core/sigmod_pkg.sv
// package for the signal modulator control block
// assumes a 32-bit AHB-Lite bus with word registers
package sigmod_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] SOURCE_OFFSET = 8'h04;
    localparam int         ADDR_LSB      = 2;
    localparam int         ADDR_W        = 8;

    // control register layout
    localparam int CTRL_EN_BIT     = 7;
    localparam int CTRL_OE_BIT     = 6;
    localparam int CTRL_SLEW_BIT   = 5;
    localparam int CTRL_INV_BIT    = 4;
    localparam int CTRL_STATUS_BIT = 3;
    localparam int CTRL_SWBIT_BIT  = 0;

    // source register layout
    localparam int SRC_DETACH_BIT = 7;
    localparam int SRC_SEL_LSB    = 0;
    localparam int SEL_W          = 4;
    localparam int NUM_SRC        = 16;

    // reset values
    localparam logic             CTRL_BIT_RST = 1'b0;
    localparam logic [SEL_W-1:0] SEL_RST      = 4'h0;
    localparam logic             DETACH_RST   = 1'b0;

    // modulating source codes
    localparam logic [SEL_W-1:0] SEL_SW_LEVEL  = 4'h0;
    localparam logic [SEL_W-1:0] SEL_EXT_PIN   = 4'h1;
    localparam logic [SEL_W-1:0] SEL_PWM1      = 4'h2;
    localparam logic [SEL_W-1:0] SEL_PWM2      = 4'h3;
    localparam logic [SEL_W-1:0] SEL_PWM3      = 4'h4;
    localparam logic [SEL_W-1:0] SEL_PWM4      = 4'h5;
    localparam logic [SEL_W-1:0] SEL_CMP1      = 4'h6;
    localparam logic [SEL_W-1:0] SEL_CMP2      = 4'h7;
    localparam logic [SEL_W-1:0] SEL_SYNC1     = 4'h8;
    localparam logic [SEL_W-1:0] SEL_SYNC2     = 4'h9;
    localparam logic [SEL_W-1:0] SEL_ASYNC_TX  = 4'hA;
    localparam logic [SEL_W-1:0] SEL_LAST_USED = 4'hA;

    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
    localparam logic        HRESP_OKAY    = 1'b0;

    // one-hot decode of a source code
    function automatic logic [NUM_SRC-1:0] sel_onehot(input logic [SEL_W-1:0] sel);
        logic [NUM_SRC-1:0] v;
        v      = '0;
        v[sel] = 1'b1;
        return v;
    endfunction

endpackage

// ### core/sigmod_mixer.sv
// source selection and carrier mixing of the signal modulator
// assumes reserved entries of the source vector are tied low
`timescale 1ns/100ps
module sigmod_mixer
    import sigmod_pkg::*;
(
    // configuration
    input  wire logic               i_enable,
    input  wire logic [SEL_W-1:0]   i_sel,
    input  wire logic               i_sw_level,
    // signals to mix
    input  wire logic [NUM_SRC-1:0] i_sources,
    input  wire logic               i_carrier_high,
    input  wire logic               i_carrier_low,
    // result
    output logic                    o_mixed
);

    logic modulating;
    logic car_high;
    logic car_low;

    // disabled: carriers grounded, modulating input is the software level
    always_comb begin
        if (!i_enable) begin
            modulating = i_sw_level;
            car_high   = 1'b0;
            car_low    = 1'b0;
        end else begin
            car_high = i_carrier_high;
            car_low  = i_carrier_low;
            if (i_sel == SEL_SW_LEVEL) begin
                modulating = i_sw_level;
            end else if (i_sel > SEL_LAST_USED) begin
                modulating = 1'b0;
            end else begin
                modulating = |(i_sources & sel_onehot(i_sel));
            end
        end
    end

    // high carrier gated while modulating is high, low carrier while low
    always_comb begin
        o_mixed = modulating ? car_high : car_low;
    end

endmodule // sigmod_mixer

// ### core/sigmod_ctrl.sv
// control and source-select logic of the data signal modulator
// assumes one AHB-Lite master, word accesses, inputs synchronous to i_clk
//
// Summary of operation
// - reset leaves the modulator disabled
// - reset clears all register fields
// - output enable bit 6 gates pin
// - bit 5 drives pad slew limiting
// - bit 4 inverts the modulated output
// - read-only status shows present output value
// - code 0000 selects software modulation bit
// - codes 0110/0111 select comparators one, two
// - codes 0010-0100 select pwm units one-three
// - output is modulating gated onto chosen carrier
// - disabled forces carriers low, software bit
// - pin held low while output disabled
// - detach bit frees selected peripheral pin
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module sigmod_ctrl
    import sigmod_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // modulating sources
    input  wire logic        i_ext_mod_pin,
    input  wire logic        i_pwm_unit1,
    input  wire logic        i_pwm_unit2,
    input  wire logic        i_pwm_unit3,
    input  wire logic        i_pwm_unit4,
    input  wire logic        i_comparator1,
    input  wire logic        i_comparator2,
    input  wire logic        i_sync_serial_unit1,
    input  wire logic        i_sync_serial_unit2,
    input  wire logic        i_async_serial_unit_tx,
    // carriers, already selected
    input  wire logic        i_carrier_high,
    input  wire logic        i_carrier_low,
    // pin side
    output logic             o_mod_pin,
    output logic             o_slew_limit,
    output logic [15:0]      o_source_pin_detach
);

    // address phase held for the data phase
    logic              wr_pend_r;
    logic              wr_pend_nxt;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [ADDR_W-1:0] wr_addr_nxt;

    // control register fields
    logic modulator_enable_r;
    logic modulator_enable_nxt;
    logic pin_output_enable_r;
    logic pin_output_enable_nxt;
    logic slew_limit_enable_r;
    logic slew_limit_enable_nxt;
    logic output_invert_r;
    logic output_invert_nxt;
    logic output_level_status_r;
    logic output_level_status_nxt;
    logic software_modulation_level_r;
    logic software_modulation_level_nxt;

    // source register fields
    logic             source_pin_detach_r;
    logic             source_pin_detach_nxt;
    logic [SEL_W-1:0] modulation_source_select_r;
    logic [SEL_W-1:0] modulation_source_select_nxt;

    // bus answer registers
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic        hreadyout_r;
    logic        hreadyout_nxt;
    logic        hresp_r;
    logic        hresp_nxt;

    // pin side registers
    logic          mod_pin_r;
    logic          mod_pin_nxt;
    logic          slew_r;
    logic          slew_nxt;
    logic [15:0]   detach_r;
    logic [15:0]   detach_nxt;

    // combinational helpers
    logic               addr_valid;
    logic [ADDR_W-1:0]  addr_word;
    logic [NUM_SRC-1:0] sources;
    logic               mixed;
    logic               shaped;

    // reserved codes stay tied low so they never connect a channel
    assign sources = {5'h00,
                      i_async_serial_unit_tx,
                      i_sync_serial_unit2,
                      i_sync_serial_unit1,
                      i_comparator2,
                      i_comparator1,
                      i_pwm_unit4,
                      i_pwm_unit3,
                      i_pwm_unit2,
                      i_pwm_unit1,
                      i_ext_mod_pin,
                      1'b0};

    // selection and carrier gating
    sigmod_mixer u_mixer (
        .i_enable       (modulator_enable_r),
        .i_sel          (modulation_source_select_r),
        .i_sw_level     (software_modulation_level_r),
        .i_sources      (sources),
        .i_carrier_high (i_carrier_high),
        .i_carrier_low  (i_carrier_low),
        .o_mixed        (mixed)
    );

    // polarity applied ahead of the pin gate
    assign shaped = mixed ^ output_invert_r;

    // address phase qualification; byte lanes inside a word are ignored
    assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ)
                        && (hsize == HSIZE_WORD);
    assign addr_word  = {haddr[ADDR_W-1:ADDR_LSB], {ADDR_LSB{1'b0}}};

    // register decode shared by the write and the read path
    function automatic logic hits_ctrl(input logic [ADDR_W-1:0] a);
        return a == CTRL_OFFSET;
    endfunction

    function automatic logic hits_source(input logic [ADDR_W-1:0] a);
        return a == SOURCE_OFFSET;
    endfunction

    // read words; unimplemented bits always come back zero
    function automatic logic [31:0] ctrl_word(
        input logic en,
        input logic oe,
        input logic slew,
        input logic inv,
        input logic status,
        input logic sw
    );
        logic [31:0] w;
        w                  = RDATA_ZERO;
        w[CTRL_EN_BIT]     = en;
        w[CTRL_OE_BIT]     = oe;
        w[CTRL_SLEW_BIT]   = slew;
        w[CTRL_INV_BIT]    = inv;
        w[CTRL_STATUS_BIT] = status;
        w[CTRL_SWBIT_BIT]  = sw;
        return w;
    endfunction

    function automatic logic [31:0] source_word(
        input logic             detach,
        input logic [SEL_W-1:0] sel
    );
        logic [31:0] w;
        w                       = RDATA_ZERO;
        w[SRC_DETACH_BIT]       = detach;
        w[SRC_SEL_LSB +: SEL_W] = sel;
        return w;
    endfunction

    // register next state
    always_comb begin
        wr_pend_nxt                   = 1'b0;
        wr_addr_nxt                   = wr_addr_r;
        modulator_enable_nxt          = modulator_enable_r;
        pin_output_enable_nxt         = pin_output_enable_r;
        slew_limit_enable_nxt         = slew_limit_enable_r;
        output_invert_nxt             = output_invert_r;
        software_modulation_level_nxt = software_modulation_level_r;
        source_pin_detach_nxt         = source_pin_detach_r;
        modulation_source_select_nxt  = modulation_source_select_r;
        // status follows the modulator, never a bus write
        output_level_status_nxt       = shaped;

        // data phase of a write
        if (wr_pend_r) begin
            if (hits_ctrl(wr_addr_r)) begin
                modulator_enable_nxt          = hwdata[CTRL_EN_BIT];
                pin_output_enable_nxt         = hwdata[CTRL_OE_BIT];
                slew_limit_enable_nxt         = hwdata[CTRL_SLEW_BIT];
                output_invert_nxt             = hwdata[CTRL_INV_BIT];
                software_modulation_level_nxt = hwdata[CTRL_SWBIT_BIT];
            end else if (hits_source(wr_addr_r)) begin
                source_pin_detach_nxt        = hwdata[SRC_DETACH_BIT];
                modulation_source_select_nxt = hwdata[SRC_SEL_LSB +: SEL_W];
            end
        end

        // address phase of a write is held for its data phase
        if (addr_valid && hwrite) begin
            wr_pend_nxt = 1'b1;
            wr_addr_nxt = addr_word;
        end
    end

    // bus answer next state; reads see any write finishing this cycle
    always_comb begin
        hrdata_nxt    = hrdata_r;
        hreadyout_nxt = 1'b1;                                       // zero wait states
        hresp_nxt     = HRESP_OKAY;
        if (addr_valid && !hwrite) begin
            if (hits_ctrl(addr_word)) begin
                hrdata_nxt = ctrl_word(modulator_enable_nxt,
                                       pin_output_enable_nxt,
                                       slew_limit_enable_nxt,
                                       output_invert_nxt,
                                       output_level_status_r,
                                       software_modulation_level_nxt);
            end else if (hits_source(addr_word)) begin
                hrdata_nxt = source_word(source_pin_detach_nxt,
                                         modulation_source_select_nxt);
            end else begin
                hrdata_nxt = RDATA_ZERO;
            end
        end
    end

    // bus and register state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_pend_r                   <= 1'b0;
            wr_addr_r                   <= CTRL_OFFSET;
            modulator_enable_r          <= CTRL_BIT_RST;
            pin_output_enable_r         <= CTRL_BIT_RST;
            slew_limit_enable_r         <= CTRL_BIT_RST;
            output_invert_r             <= CTRL_BIT_RST;
            output_level_status_r       <= CTRL_BIT_RST;
            software_modulation_level_r <= CTRL_BIT_RST;
            source_pin_detach_r         <= DETACH_RST;
            modulation_source_select_r  <= SEL_RST;
        end else begin
            wr_pend_r                   <= wr_pend_nxt;
            wr_addr_r                   <= wr_addr_nxt;
            modulator_enable_r          <= modulator_enable_nxt;
            pin_output_enable_r         <= pin_output_enable_nxt;
            slew_limit_enable_r         <= slew_limit_enable_nxt;
            output_invert_r             <= output_invert_nxt;
            output_level_status_r       <= output_level_status_nxt;
            software_modulation_level_r <= software_modulation_level_nxt;
            source_pin_detach_r         <= source_pin_detach_nxt;
            modulation_source_select_r  <= modulation_source_select_nxt;
        end
    end

    // bus answer registers; ready stays high through reset as well
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hrdata_r    <= RDATA_ZERO;
            hreadyout_r <= 1'b1;
            hresp_r     <= HRESP_OKAY;
        end else begin
            hrdata_r    <= hrdata_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r     <= hresp_nxt;
        end
    end

    // pin side next state
    always_comb begin
        // gated low, mixing keeps running behind the gate
        mod_pin_nxt = pin_output_enable_r ? shaped : 1'b0;
        slew_nxt    = slew_limit_enable_r;
        detach_nxt  = '0;
        // only the selected peripheral loses its own pin
        if (source_pin_detach_r && modulation_source_select_r != SEL_SW_LEVEL) begin
            detach_nxt = sel_onehot(modulation_source_select_r);
        end
    end

    // pin side registers; one cycle of latency on the pin
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mod_pin_r <= 1'b0;
            slew_r    <= CTRL_BIT_RST;
            detach_r  <= '0;
        end else begin
            mod_pin_r <= mod_pin_nxt;
            slew_r    <= slew_nxt;
            detach_r  <= detach_nxt;
        end
    end

    // outputs straight from flops
    assign hrdata              = hrdata_r;
    assign hreadyout           = hreadyout_r;
    assign hresp               = hresp_r;
    assign o_mod_pin           = mod_pin_r;
    assign o_slew_limit        = slew_r;
    assign o_source_pin_detach = detach_r;

endmodule // sigmod_ctrl

// ### testbench/sigmod_sva.sv
// assertions on the ports of the signal modulator control block
// assumes word accesses and inputs synchronous to i_clk
`timescale 1ns/100ps
module sigmod_sva
    import sigmod_pkg::*;
(
    // clock, reset and bus
    input wire logic        i_clk, i_sys_rst, hsel, hwrite, hready,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0]  htrans,
    input wire logic [2:0]  hsize,
    // sources and carriers
    input wire logic        i_ext_mod_pin, i_pwm_unit1, i_pwm_unit2, i_pwm_unit3,
    input wire logic        i_pwm_unit4, i_comparator1, i_comparator2, i_sync_serial_unit1,
    input wire logic        i_sync_serial_unit2, i_async_serial_unit_tx,
    input wire logic        i_carrier_high, i_carrier_low,
    // pin side
    input wire logic        o_mod_pin, o_slew_limit,
    input wire logic [15:0] o_source_pin_detach
);
    logic        take, aw_r, ar_r, mod, shp;
    logic [5:0]  aa_r;
    logic [7:0]  ctl_r, src_r;
    logic [15:0] srcv;

    // expected pin level from the shadowed registers
    assign take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
    assign srcv = {5'h00, i_async_serial_unit_tx, i_sync_serial_unit2, i_sync_serial_unit1,
                   i_comparator2, i_comparator1, i_pwm_unit4, i_pwm_unit3, i_pwm_unit2,
                   i_pwm_unit1, i_ext_mod_pin, ctl_r[0]};
    assign mod  = ctl_r[7] ? srcv[src_r[3:0]] : ctl_r[0];
    assign shp  = (ctl_r[7] && (mod ? i_carrier_high : i_carrier_low)) ^ ctl_r[4];

    // shadow registers; masks drop the read-only and unused bits
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {aw_r, ar_r, aa_r, ctl_r, src_r} <= '0;
        end else begin
            aw_r <= take && hwrite;
            ar_r <= take && !hwrite;
            aa_r <= haddr[7:2];
            if (aw_r && aa_r == 6'h00) ctl_r <= hwdata[7:0] & 8'hF1;
            if (aw_r && aa_r == 6'h01) src_r <= hwdata[7:0] & 8'h8F;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_pin_held_low: assert property (!ctl_r[6] |=> !o_mod_pin)
        else $error("pin not low while output disabled");
    a_pin_follows: assert property (ctl_r[6] && ctl_r[7] |=> o_mod_pin == $past(shp))
        else $error("pin differs from mixed source");
    a_disabled_level: assert property (ctl_r[6] && !ctl_r[7] |=> o_mod_pin == $past(ctl_r[4]))
        else $error("disabled pin not at polarity level");
    a_reserved_low: assert property (ctl_r[6] && ctl_r[7] && src_r[3:0] > 4'hA
        |=> o_mod_pin == $past(i_carrier_low ^ ctl_r[4])) else $error("reserved code not low");
    a_slew_copy: assert property ($stable(ctl_r[5]) |-> o_slew_limit == ctl_r[5])
        else $error("slew output differs from control");
    a_detach_map: assert property ($stable(src_r) |-> o_source_pin_detach ==
        ((src_r[7] && src_r[3:0] != 4'h0) ? (16'h0001 << src_r[3:0]) : 16'h0000))
        else $error("detach output wrong");
    a_ctrl_read: assert property (ar_r && aa_r == 6'h00
        |-> (hrdata & 32'hFFFF_FFF7) == {24'h000000, ctl_r & 8'hF7}) else $error("ctrl read");
    a_status_read: assert property (ar_r && aa_r == 6'h00 |-> hrdata[3] == $past(shp, 2))
        else $error("status bit wrong");
    a_src_read: assert property (ar_r && aa_r == 6'h01 |-> hrdata == {24'h000000, src_r})
        else $error("source read wrong");
    a_unmapped_zero: assert property (ar_r && aa_r > 6'h01 |-> hrdata == RDATA_ZERO)
        else $error("unmapped read not zero");
endmodule // sigmod_sva

// ### testbench/sigmod_src_model.sv
// model of the peripherals feeding modulating sources and carriers
// assumes the bench samples these levels on the falling edge
`timescale 1ns/100ps
module sigmod_src_model (
    // control
    input  wire logic        i_clk,
    input  wire logic        i_run,
    // carriers low/high in 11:10, sources in 9:0
    output logic      [11:0] o_src
);
    int seed = 32'hA6D35956;

    // levels change every cycle while running, hold otherwise
    initial o_src = 12'h000;
    always @(posedge i_clk) begin
        if (i_run) o_src <= 12'($random(seed));
    end
endmodule // sigmod_src_model

// ### testbench/testbench.sv
// self-checking bench for the signal modulator control block
// assumes one AHB-Lite master with hready tied to hreadyout
`timescale 1ns/100ps
module testbench
    import sigmod_pkg::*;
;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        run = 1'b0, dp = 1'b0, pin_on = 1'b0, pin_exp = 1'b0, m, st;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q[$];
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [7:0]  ctl = 8'h00, sel = 8'h00;
    logic [15:0] vec;
    wire logic   hready, hreadyout, hresp, o_mod_pin, o_slew_limit, i_carrier_low;
    wire logic   i_carrier_high, i_async_serial_unit_tx, i_sync_serial_unit2;
    wire logic   i_sync_serial_unit1, i_comparator2, i_comparator1, i_pwm_unit4;
    wire logic   i_pwm_unit3, i_pwm_unit2, i_pwm_unit1, i_ext_mod_pin;
    wire logic [31:0] hrdata;
    wire logic [15:0] o_source_pin_detach;
    wire logic [11:0] src;
    int          errors = 0, compares = 0, cycles = 0, code;

    assign hready = hreadyout;
    assign {i_carrier_low, i_carrier_high, i_async_serial_unit_tx, i_sync_serial_unit2,
            i_sync_serial_unit1, i_comparator2, i_comparator1, i_pwm_unit4, i_pwm_unit3,
            i_pwm_unit2, i_pwm_unit1, i_ext_mod_pin} = src;
    sigmod_ctrl u_sigmod_ctrl (.*);
    sigmod_src_model u_sigmod_src_model (.i_clk(i_clk), .i_run(run), .o_src(src));

    always #5 i_clk = ~i_clk;

    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one transfer; the master waits on hready, never a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        dp     <= !w;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        dp <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // source settings go in before the pin is trusted
    task automatic set(input logic [7:0] c, input logic [7:0] s);
        pin_on <= 1'b0;
        bus(1'b1, CTRL_OFFSET, {24'h000000, c});
        bus(1'b1, SOURCE_OFFSET, {24'h000000, s});
        ctl <= c & 8'hF1;
        sel <= s & 8'h8F;
        idle(3);
        pin_on <= 1'b1;
    endtask

    // oldest read note meets the data phase; pin predicted one edge ahead
    // looked at on the falling edge, clear of the edge that launches outputs
    always @(negedge i_clk) begin
        if (dp) begin
            chk(hrdata, q.pop_front());
            chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
        end
        if (pin_on) chk({31'h0, o_mod_pin}, {31'h0, pin_exp});
        vec = {5'h00, src[9:0], ctl[0]};
        m = ctl[7] ? vec[sel[3:0]] : ctl[0];
        pin_exp = ctl[6] & ((ctl[7] & (m ? src[10] : src[11])) ^ ctl[4]);
        cycles++;
        if (cycles > 5000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        idle(6);
        i_sys_rst <= 1'b0;
        idle(1);
        rd(CTRL_OFFSET, 32'h0);
        rd(SOURCE_OFFSET, 32'h0);
        rd(8'h10, RDATA_ZERO);
        chk({o_mod_pin, o_slew_limit, o_source_pin_detach}, 32'h0);
        // disabled with static inputs: pin sits at the polarity level
        set(8'h7F, 8'hF6);
        rd(CTRL_OFFSET, 32'h79);
        rd(SOURCE_OFFSET, 32'h86);
        chk(o_slew_limit, 32'h1);
        chk(o_source_pin_detach, 32'h40);
        run <= 1'b1;
        for (code = 0; code < 16; code++) begin
            set(8'hC0 | (code[0] << 4) | code[1], 8'h80 | code[3:0]);
            idle(20);
            chk(o_source_pin_detach, code ? (32'h1 << code) : 32'h0);
        end
        set(8'hB1, 8'h87);
        idle(10);
        chk(o_source_pin_detach, 32'h80);
        // frozen sources, so the status bit can be trusted
        run <= 1'b0;
        idle(2);
        st = (src[6] ? src[10] : src[11]) ^ 1'b1;
        rd(CTRL_OFFSET, {24'h000000, 8'hB1 | {4'h0, st, 3'h0}});
        // a byte-sized write is refused
        hsize <= 3'h0;
        bus(1'b1, CTRL_OFFSET, 32'h0000_0000);
        hsize <= HSIZE_WORD;
        rd(CTRL_OFFSET, {24'h000000, 8'hB1 | {4'h0, st, 3'h0}});
        // second reset in mid-run
        pin_on <= 1'b0;
        run <= 1'b0;
        i_sys_rst <= 1'b1;
        idle(2);
        i_sys_rst <= 1'b0;
        ctl <= 8'h00;
        sel <= 8'h00;
        idle(1);
        chk({o_mod_pin, o_slew_limit, o_source_pin_detach}, 32'h0);
        rd(CTRL_OFFSET, 32'h0);
        rd(SOURCE_OFFSET, 32'h0);
        final_report();
    end
endmodule // testbench

bind sigmod_ctrl sigmod_sva u_sigmod_sva (.*);
